// ### pkg/rco_defines.svh
// Purpose: register offsets, field positions and reset values of the
//          reference clock output divider
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   definitions only
`ifndef RCO_DEFINES_SVH
`define RCO_DEFINES_SVH

// register byte offsets
`define RCO_OFS_CTRL 8'h00
`define RCO_OFS_STATUS 8'h04
`define RCO_OFS_PERIODS 8'h08

// control register field positions
`define RCO_CTRL_EN_BIT 7
`define RCO_CTRL_DUTY_HI 4
`define RCO_CTRL_DUTY_LO 3
`define RCO_CTRL_DIV_HI 2
`define RCO_CTRL_DIV_LO 0

// implemented control bits: 7 and 4..0
`define RCO_CTRL_WMASK 8'h9F
// reset: enable off, duty 50 percent, no division
`define RCO_CTRL_RESET 8'h10

// status register field positions
`define RCO_STAT_RUN_BIT 0
`define RCO_STAT_HOLD_BIT 1
`define RCO_STAT_WAVE_BIT 2
`define RCO_STAT_BYP_BIT 3
`define RCO_STAT_DIV_LO 8
`define RCO_STAT_DUTY_LO 11
`define RCO_STAT_CNT_LO 16

`endif

// ### pkg/rco_pkg.sv
// Purpose: types shared by the reference clock output divider
// Assumes: nothing beyond the defines header
// Notes:   no constants here; offsets live in rco_defines.svh
package rco_pkg;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic en;
        logic [1:0] rsvd;
        logic [1:0] duty;
        logic [2:0] div;
    } rco_ctrl_type;

    // phase lengths of one divided period
    typedef struct packed {
        logic [7:0] high;
        logic [6:0] term;
        logic bypass;
    } rco_phase_type;

    typedef enum logic [2:0] {
        RCO_IDLE = 3'b001,
        RCO_RUN = 3'b010,
        RCO_HOLD = 3'b100
    } rco_state_type;

endpackage

// ### src/rco_duty_calc.sv
// Purpose: turn divider and duty codes into phase lengths
// Assumes: codes come straight from the control register
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none

module rco_duty_calc (
    input wire logic [2:0] div,
    input wire logic [1:0] duty,
    output rco_pkg::rco_phase_type phase
);

    logic [7:0] ratio;
    logic [9:0] prod;

    // high phase is ratio * duty / 4, at least one cycle unless duty is 0
    always_comb begin
        ratio = 8'h01 << div;
        prod = 10'(ratio) * 10'(duty);
        phase.term = 7'(ratio - 8'h01);
        phase.bypass = (div == 3'h0);
        if (duty == 2'h0) begin
            phase.high = 8'h00;
        end else if (prod[9:2] == 8'h00) begin
            phase.high = 8'h01;
        end else begin
            phase.high = prod[9:2];
        end
    end

endmodule
`default_nettype wire

// ### src/rco_clk_gate.sv
// Purpose: glitch-free output stage of the reference clock
// Assumes: enable and run change only just after a rising pclk edge
// Notes:   the bypass gate is retimed on the falling edge
`timescale 1ns/1ns
`default_nettype none

module rco_clk_gate (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic run_bypass,
    input wire logic bypass,
    input wire logic wave,
    output logic clk_out
);

    logic gate_ff;
    logic nxt_gate;

    // gate opens only while pclk is low, so no first pulse is cut
    always_comb begin
        nxt_gate = run_bypass;
    end

    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_ff <= 1'b0;
        end else begin
            gate_ff <= nxt_gate;
        end
    end

    // dropping enable kills the output at once, mid period if need be
    always_comb begin
        if (!enable) begin
            clk_out = 1'b0;
        end else if (bypass) begin
            clk_out = pclk & gate_ff;
        end else begin
            clk_out = wave;
        end
    end

endmodule
`default_nettype wire

// ### src/rco_refclk_top.sv
// Purpose: reference clock output divider with an APB control port
// Assumes: pclk is the system clock; sys_sleep marks the clock stopping
// Notes:   zero wait state APB slave; output is also fed internally
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rco_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Contract
// R1: output derived from the system clock only
// R2: enabling starts output without glitch
// R3: disabling stops output immediately
// R4: divider code n divides by two power n
// R5: duty codes 11,10,01 give 75,50,25 percent; divider code 1 gives 50 percent for all three
// R6: duty code 00 keeps output low
// R7: undivided setting follows system clock, ignores duty
// R8: reset gives disabled, 50 percent, no division
// R9: software changes settings only while disabled
// R10: sleep holds the output at its level
// R11: enable is bit 7, read-write
// R12: duty bits 4-3, divider bits 2-0, read-write
// R13: bits 6-5 ignore writes, read zero
// R14: generated clock also drives internal peripherals
// R15: settings latched at period restart, counter phases
module rco_refclk_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sys_sleep,
    output logic ref_clock_out_pin,
    output logic refclk_internal_src
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    rco_pkg::rco_ctrl_type ctrl_ff;
    rco_pkg::rco_ctrl_type nxt_ctrl;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;

    rco_pkg::rco_state_type state_ff;
    rco_pkg::rco_state_type nxt_state;
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    logic wave_ff;
    logic nxt_wave;
    logic [7:0] lat_high_ff;
    logic [7:0] nxt_lat_high;
    logic [6:0] lat_term_ff;
    logic [6:0] nxt_lat_term;
    logic lat_bypass_ff;
    logic nxt_lat_bypass;
    logic [2:0] lat_div_ff;
    logic [2:0] nxt_lat_div;
    logic [1:0] lat_duty_ff;
    logic [1:0] nxt_lat_duty;
    logic [15:0] periods_ff;
    logic [15:0] nxt_periods;

    rco_pkg::rco_phase_type new_phase;
    logic setup_phase;
    logic access_phase;
    logic addr_hit;
    logic [31:0] status_word;
    logic [6:0] cnt_inc;
    logic clk_out;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // setup cycle prepares read data; access cycle commits writes
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;

    // only the three words below answer without error
    always_comb begin
        case (paddr)
            `RCO_OFS_CTRL: addr_hit = 1'b1;
            `RCO_OFS_STATUS: addr_hit = 1'b1;
            `RCO_OFS_PERIODS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // no wait states; unmapped words flag an error in the access cycle
    assign pready = 1'b1;
    assign pslverr = access_phase & ~addr_hit;
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // status word

    // live view of the generator for software
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`RCO_STAT_RUN_BIT] = (state_ff == rco_pkg::RCO_RUN);
        status_word[`RCO_STAT_HOLD_BIT] = (state_ff == rco_pkg::RCO_HOLD);
        status_word[`RCO_STAT_WAVE_BIT] = wave_ff;
        status_word[`RCO_STAT_BYP_BIT] = lat_bypass_ff;
        status_word[`RCO_STAT_DIV_LO +: 3] = lat_div_ff;
        status_word[`RCO_STAT_DUTY_LO +: 2] = lat_duty_ff;
        status_word[`RCO_STAT_CNT_LO +: 7] = cnt_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and read data

    // byte lane 0 carries the whole control register
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_prdata = prdata_ff;
        if (access_phase && pwrite && pstrb[0] &&
            paddr == `RCO_OFS_CTRL) begin
            // unimplemented bits never store a one, see R13
            nxt_ctrl = rco_pkg::rco_ctrl_type'(pwdata[7:0] &
                `RCO_CTRL_WMASK); // see R11 see R12
        end
        if (setup_phase && !pwrite) begin
            case (paddr)
                `RCO_OFS_CTRL: begin
                    // reserved bits read zero, see R13
                    nxt_prdata = {24'h00_0000,
                        8'(ctrl_ff) & `RCO_CTRL_WMASK};
                end
                `RCO_OFS_STATUS: begin
                    nxt_prdata = status_word;
                end
                `RCO_OFS_PERIODS: begin
                    nxt_prdata = {16'h0000, periods_ff};
                end
                default: begin
                    nxt_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // reset value: disabled, duty 50 percent, divide by one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= rco_pkg::rco_ctrl_type'(`RCO_CTRL_RESET); // see R8
            prdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            prdata_ff <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // phase lengths of the settings software holds now

    // divide by two to the power of the divider code, see R4
    rco_duty_calc u_calc (
        .div(ctrl_ff.div),
        .duty(ctrl_ff.duty),
        .phase(new_phase)
    );

    assign cnt_inc = cnt_ff + 7'h01;

    ////////////////////////////////////////////////////////////////////////
    // divider state machine

    // counter on pclk makes each high and low phase, see R1 see R15
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_wave = wave_ff;
        nxt_lat_high = lat_high_ff;
        nxt_lat_term = lat_term_ff;
        nxt_lat_bypass = lat_bypass_ff;
        nxt_lat_div = lat_div_ff;
        nxt_lat_duty = lat_duty_ff;
        nxt_periods = periods_ff;
        case (state_ff)
            rco_pkg::RCO_IDLE: begin
                nxt_cnt = 7'h00;
                nxt_wave = 1'b0;
                nxt_periods = 16'h0000;
                if (ctrl_ff.en && !sys_sleep) begin
                    // start a fresh period with the new settings, see R2
                    nxt_state = rco_pkg::RCO_RUN;
                    nxt_lat_high = new_phase.high;
                    nxt_lat_term = new_phase.term;
                    nxt_lat_bypass = new_phase.bypass;
                    nxt_lat_div = ctrl_ff.div;
                    nxt_lat_duty = ctrl_ff.duty;
                    // duty 00 never raises the divided output, see R5 see R6
                    nxt_wave = (new_phase.high != 8'h00);
                end
            end
            rco_pkg::RCO_RUN: begin
                if (!ctrl_ff.en) begin
                    // counter abandoned mid period, see R3
                    nxt_state = rco_pkg::RCO_IDLE;
                    nxt_cnt = 7'h00;
                    nxt_wave = 1'b0;
                end else if (sys_sleep) begin
                    // freeze everything where it stands, see R10
                    nxt_state = rco_pkg::RCO_HOLD;
                end else if (cnt_ff == lat_term_ff) begin
                    // period restarts: settings sampled here, see R15
                    nxt_cnt = 7'h00;
                    nxt_lat_high = new_phase.high;
                    nxt_lat_term = new_phase.term;
                    nxt_lat_bypass = new_phase.bypass;
                    nxt_lat_div = ctrl_ff.div;
                    nxt_lat_duty = ctrl_ff.duty;
                    nxt_wave = (new_phase.high != 8'h00); // see R5 see R6
                    nxt_periods = periods_ff + 16'h0001;
                end else begin
                    nxt_cnt = cnt_inc;
                    nxt_wave = ({1'b0, cnt_inc} < lat_high_ff); // see R5
                end
            end
            rco_pkg::RCO_HOLD: begin
                if (!ctrl_ff.en) begin
                    nxt_state = rco_pkg::RCO_IDLE;
                    nxt_cnt = 7'h00;
                    nxt_wave = 1'b0;
                end else if (!sys_sleep) begin
                    // clock back: continue the same period, see R10
                    nxt_state = rco_pkg::RCO_RUN;
                end
            end
            default: begin
                nxt_state = rco_pkg::RCO_IDLE;
                nxt_cnt = 7'h00;
                nxt_wave = 1'b0;
            end
        endcase
    end

    // state, counter and latched settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= rco_pkg::RCO_IDLE;
            cnt_ff <= 7'h00;
            wave_ff <= 1'b0;
            lat_high_ff <= 8'h00;
            lat_term_ff <= 7'h00;
            lat_bypass_ff <= 1'b1;
            lat_div_ff <= 3'h0;
            lat_duty_ff <= 2'h2;
            periods_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            wave_ff <= nxt_wave;
            lat_high_ff <= nxt_lat_high;
            lat_term_ff <= nxt_lat_term;
            lat_bypass_ff <= nxt_lat_bypass;
            lat_div_ff <= nxt_lat_div;
            lat_duty_ff <= nxt_lat_duty;
            periods_ff <= nxt_periods;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage

    // undivided setting passes pclk itself and ignores duty, see R7
    rco_clk_gate u_gate (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl_ff.en),
        .run_bypass(ctrl_ff.en & lat_bypass_ff &
            (state_ff == rco_pkg::RCO_RUN)),
        .bypass(lat_bypass_ff),
        .wave(wave_ff),
        .clk_out(clk_out)
    );

    // pin and internal source carry the same clock, see R14
    assign ref_clock_out_pin = clk_out;
    assign refclk_internal_src = clk_out;

endmodule
`default_nettype wire

// ### verification/rco_refclk_asserts.sv
// Purpose: checker for the reference clock output divider
// Assumes: sees only the top ports; pclk is the sole clock
// Notes: keeps a shadow of the control register
`timescale 1ns/1ns
`default_nettype none
module rco_refclk_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sys_sleep,
    input wire logic ref_clock_out_pin,
    input wire logic refclk_internal_src
);
    logic [7:0] shadow_ff;
    logic [7:0] nxt_shadow;
    logic acc;
    logic setup;
    logic mapped;
    logic ctrl_wr;
    // bus phase decode
    assign acc = psel && penable;
    assign setup = psel && !penable;
    assign mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
    assign ctrl_wr = acc && pwrite && paddr == 8'h00 && pstrb[0];
    // shadow control register, only implemented bits kept
    always_comb begin
        nxt_shadow = shadow_ff;
        if (ctrl_wr) begin
            nxt_shadow = pwdata[7:0] & 8'h9F;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_ff <= 8'h10;
        end else begin
            shadow_ff <= nxt_shadow;
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_decode: assert property (pslverr == (acc && !mapped))
        else $error("pslverr wrong");
    chk_ctrl_readback: assert property (
        setup && !pwrite && paddr == 8'h00 |=>
        prdata == {24'h000000, $past(shadow_ff)})
        else $error("control readback wrong");
    chk_unmapped_zero: assert property (
        setup && !pwrite && !mapped |=> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_internal_copy: assert property (
        refclk_internal_src == ref_clock_out_pin)
        else $error("internal source differs from pin");
    chk_off_low: assert property (
        !shadow_ff[7] |-> !ref_clock_out_pin)
        else $error("output active while disabled");
    chk_sleep_hold: assert property (
        $past(sys_sleep, 3) && $past(sys_sleep, 2) && $past(sys_sleep) &&
        sys_sleep && shadow_ff[7] && $past(shadow_ff[7]) |->
        $stable(ref_clock_out_pin))
        else $error("output moved in sleep");
    chk_start_clean: assert property (
        ctrl_wr && !shadow_ff[7] && pwdata[7] && pwdata[4:3] != 2'b00 &&
        pwdata[2:0] != 3'b000 |=> !ref_clock_out_pin ##1 ref_clock_out_pin)
        else $error("start pulse wrong");
endmodule
bind rco_refclk_top rco_refclk_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_sleep(sys_sleep), .ref_clock_out_pin(ref_clock_out_pin),
    .refclk_internal_src(refclk_internal_src));
`default_nettype wire

// ### verification/rco_pin_monitor.sv
// Purpose: model of the load on the reference clock pin
// Assumes: divided output changes just after rising pclk
// Notes: measures period, high time and rising edges
`timescale 1ns/1ns
`default_nettype none
module rco_pin_monitor (
    input wire logic pclk,
    input wire logic ref_in,
    output logic [15:0] period,
    output logic [15:0] high,
    output logic [15:0] rises
);
    logic [15:0] cnt;
    logic [15:0] hcnt;
    logic last;
    initial begin
        {period, high, rises, cnt, hcnt, last} = '0;
    end
    // sample at falling pclk, away from the launching edge
    always @(negedge pclk) begin
        if (ref_in && !last) begin
            period <= cnt;
            rises <= rises + 16'h0001;
            cnt <= 16'h0001;
            hcnt <= 16'h0001;
        end else begin
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + {15'h0000, ref_in};
        end
        if (!ref_in && last) begin
            high <= hcnt;
        end
        last <= ref_in;
    end
endmodule
`default_nettype wire

// ### verification/rco_refclk_top_tb_top.sv
// Purpose: self-checking bench of the reference clock divider
// Assumes: zero wait state slave, pclk 25 MHz
// Notes: sweeps divider codes 1 to 7 with every duty code
`timescale 1ns/1ns
`default_nettype none
module rco_refclk_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
    logic sys_sleep, pin, isrc, lvl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] m_per, m_high, m_rises, r0;
    int fail_count, checks, n, h;
    rco_refclk_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_sleep(sys_sleep),
        .ref_clock_out_pin(pin), .refclk_internal_src(isrc));
    rco_pin_monitor mon (.pclk(pclk), .ref_in(pin), .period(m_per),
        .high(m_high), .rises(m_rises));
    // 40 ns clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic end_sim;
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            fail_count++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, sys_sleep, presetn} = '0;
        {paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 8'h00, 32'h0);
        check("ctrl_reset", rd, 32'h00000010);
        xfer(1'b1, 8'h00, 32'hFFFFFFFF);
        xfer(1'b0, 8'h00, 32'h0);
        check("ctrl_mask", rd, 32'h0000009F);
        xfer(1'b1, 8'h00, 32'h00000060);
        xfer(1'b0, 8'h00, 32'h0);
        check("ctrl_rsvd", rd, 32'h00000000);
        xfer(1'b0, 8'h0C, 32'h0);
        check("unmapped", {rd[30:0], err}, 32'h00000001);
        for (int d = 1; d < 8; d++) begin
            for (int c = 0; c < 4; c++) begin
                n = 1 << d;
                h = (n * c / 4 == 0 && c != 0) ? 1 : n * c / 4;
                xfer(1'b1, 8'h00, 32'h0);
                r0 = m_rises;
                xfer(1'b1, 8'h00, 32'h80 | (c << 3) | d);
                repeat (3 * n + 4) @(posedge pclk);
                if (c == 0) begin
                    check("dark", {16'h0, m_rises}, {16'h0, r0});
                end else begin
                    check("period", {16'h0, m_per}, n);
                    check("high", {16'h0, m_high}, h);
                    // first rise one edge after enable, then one per n
                    check("rises", {16'h0, m_rises - r0},
                        (n == 2) ? 5 : 4);
                end
            end
        end
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b1, 8'h00, 32'h80);
        repeat (3) @(posedge pclk);
        repeat (3) begin
            @(posedge pclk);
            #10 check("byp_hi", {30'h0, isrc, pin}, 32'h3);
            @(negedge pclk);
            #10 check("byp_lo", {31'h0, pin}, 32'h0);
        end
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b1, 8'h00, 32'h9F);
        repeat (20) @(posedge pclk);
        #1 check("pre_off", {31'h0, pin}, 32'h1);
        xfer(1'b1, 8'h00, 32'h0);
        #1 check("off_now", {31'h0, pin}, 32'h0);
        xfer(1'b1, 8'h00, 32'h93);
        repeat (5) @(posedge pclk);
        sys_sleep <= 1'b1;
        repeat (4) @(posedge pclk);
        #1 lvl = pin;
        r0 = m_rises;
        // frozen at count 4 of 8, wave low, divide by 8, duty 50 percent
        xfer(1'b0, 8'h04, 32'h0);
        check("sleep_stat", rd, 32'h00041302);
        repeat (40) @(posedge pclk);
        #1 check("sleep_lvl", {31'h0, pin}, {31'h0, lvl});
        check("sleep_edges", {16'h0, m_rises}, {16'h0, r0});
        @(posedge pclk);
        sys_sleep <= 1'b0;
        repeat (30) @(posedge pclk);
        check("wake_period", {16'h0, m_per}, 32'h8);
        // the cut period finishes after wake, then three whole ones
        xfer(1'b0, 8'h08, 32'h0);
        check("periods", rd, 32'h00000004);
        end_sim();
    end
endmodule
`default_nettype wire
